// ==== rtl/phs_alu.sv ====
// Packed halving lane datapath with bit and equivalence tests, registered one stage.
// Assumes the pipeline presents one decoded request per cycle with req_valid high.
//
// Summary of operation
// - Halving add-sub exchange: upper = (first upper + second lower) halved.
// - Halving add-sub exchange: lower = (first lower - second upper) halved.
// - Halving sub-add exchange: upper = (first upper - second lower) halved.
// - Halving sub-add exchange: lower = (first lower + second upper) halved.
// - Lane operations never change any condition flag.
// - Halving halfword subtract halves each lane difference.
// - Halving byte subtract halves each of four byte differences.
// - Halfword subtract gives two plain signed differences.
// - Byte subtract gives four plain signed differences.
// - Add-sub exchange: upper = first upper + second lower; lower = difference.
// - Sub-add exchange: lower = crossed sum, upper = crossed difference, unhalved.
// - Bit test ANDs operands, sets flags, writes no register.
// - Equivalence test XORs operands, sets flags, discards the value.
// - Tests set negative and zero, carry from shifter, keep overflow.
// - After equivalence test, negative equals XOR of operand sign bits.
// - A failed condition commits neither result nor flags.
// - Without a destination the result goes to the first operand register.
`timescale 1ns/1ns
`default_nettype none
module phs_alu (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              req_valid,
  input  wire phs_pkg::phs_req_t req,
  output logic                   done_q,
  output logic                   wr_en_q,
  output logic [3:0]             wr_idx_q,
  output logic [31:0]            wr_data_q,
  output logic                   reg_fault_q,
  output phs_pkg::phs_flags_t    flags_q
);

  ////////////////////////////////////////////////////////////////////////////////
  logic        is_test;
  logic        bad_reg;
  logic        commit;
  logic [31:0] lane_res;
  logic [31:0] test_val;

  phs_lane_unit u_lane (
    .op     (req.op),
    .a      (req.first_val),
    .b      (req.second_val),
    .result (lane_res)
  );

  assign is_test  = (req.op == phs_pkg::OP_BIT_TEST) || (req.op == phs_pkg::OP_EQUIV_TEST);
  assign test_val = (req.op == phs_pkg::OP_BIT_TEST)
                  ? (req.first_val & req.second_val)
                  : (req.first_val ^ req.second_val);

  // A forbidden register is refused rather than executed, so a bad encoding cannot
  // corrupt the register file or the flags.
  assign bad_reg = phs_pkg::phs_resv_idx(req.first_idx)
                || (req.second_is_reg && phs_pkg::phs_resv_idx(req.second_idx))
                || (!is_test && req.dest_given && phs_pkg::phs_resv_idx(req.dest_idx));

  assign commit = req_valid && req.cond_pass && !bad_reg;

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      done_q      <= 1'b0;
      reg_fault_q <= 1'b0;
    end
    else
    begin
      done_q      <= req_valid;
      reg_fault_q <= req_valid && bad_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_en_q   <= 1'b0;
      wr_idx_q  <= 4'h0;
      wr_data_q <= 32'h0;
    end
    else
    begin
      wr_en_q <= commit && !is_test;
      if (commit && !is_test)
      begin
        wr_idx_q  <= req.dest_given ? req.dest_idx : req.first_idx;
        wr_data_q <= lane_res;
      end
    end
  end

  // Only the tests touch the flags; the lane operations leave them as they were.
  always_ff @(posedge clk)
  begin
    if (rst)
      flags_q <= phs_pkg::FLAGS_RST;
    else if (commit && is_test)
    begin
      flags_q.n <= test_val[31];
      flags_q.z <= (test_val == 32'h0);
      if (req.shift_carry_valid)
        flags_q.c <= req.shift_carry;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  phs_pkg::phs_req_t req_q;
  logic              commit_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      req_q    <= '0;
      commit_q <= 1'b0;
    end
    else
    begin
      req_q    <= req;
      commit_q <= commit;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_XHALF_AS_UPPER: assert property (
    commit_q && req_q.op == phs_pkg::OP_HALVE_ADD_SUB_X |->
    wr_data_q[31:16] == phs_pkg::phs_half16(req_q.first_val[31:16], req_q.second_val[15:0], 1'b0))
    else $error("halving add-sub exchange upper lane wrong");
  AST_XHALF_AS_LOWER: assert property (
    commit_q && req_q.op == phs_pkg::OP_HALVE_ADD_SUB_X |->
    wr_data_q[15:0] == phs_pkg::phs_half16(req_q.first_val[15:0], req_q.second_val[31:16], 1'b1))
    else $error("halving add-sub exchange lower lane wrong");
  AST_XHALF_SA_UPPER: assert property (
    commit_q && req_q.op == phs_pkg::OP_HALVE_SUB_ADD_X |->
    wr_data_q[31:16] == phs_pkg::phs_half16(req_q.first_val[31:16], req_q.second_val[15:0], 1'b1))
    else $error("halving sub-add exchange upper lane wrong");
  AST_XHALF_SA_LOWER: assert property (
    commit_q && req_q.op == phs_pkg::OP_HALVE_SUB_ADD_X |->
    wr_data_q[15:0] == phs_pkg::phs_half16(req_q.first_val[15:0], req_q.second_val[31:16], 1'b0))
    else $error("halving sub-add exchange lower lane wrong");
  AST_LANE_FLAGS_HOLD: assert property (req_valid && !is_test |=> $stable(flags_q))
    else $error("lane operation changed flags");
  AST_HALF_SUB16_LANES: assert property (
    commit_q && req_q.op == phs_pkg::OP_HALVE_SUB16 |->
    wr_data_q == {phs_pkg::phs_half16(req_q.first_val[31:16], req_q.second_val[31:16], 1'b1),
                  phs_pkg::phs_half16(req_q.first_val[15:0], req_q.second_val[15:0], 1'b1)})
    else $error("halving halfword subtract wrong");
  AST_HALF_SUB8_ENDS: assert property (
    commit_q && req_q.op == phs_pkg::OP_HALVE_SUB8 |->
    wr_data_q[31:24] == phs_pkg::phs_half8(req_q.first_val[31:24], req_q.second_val[31:24], 1'b1)
    && wr_data_q[7:0] == phs_pkg::phs_half8(req_q.first_val[7:0], req_q.second_val[7:0], 1'b1))
    else $error("halving byte subtract wrong");
  AST_LANE_SUB16: assert property (commit_q && req_q.op == phs_pkg::OP_LANE_SUB16 |->
    wr_data_q[15:0] == 16'(req_q.first_val[15:0] - req_q.second_val[15:0])
    && wr_data_q[31:16] == 16'(req_q.first_val[31:16] - req_q.second_val[31:16]))
    else $error("halfword subtract wrong");
  AST_LANE_SUB8: assert property (commit_q && req_q.op == phs_pkg::OP_LANE_SUB8 |->
    wr_data_q[15:8] == 8'(req_q.first_val[15:8] - req_q.second_val[15:8])
    && wr_data_q[23:16] == 8'(req_q.first_val[23:16] - req_q.second_val[23:16]))
    else $error("byte subtract wrong");
  AST_ADD_SUB_X: assert property (commit_q && req_q.op == phs_pkg::OP_ADD_SUB_X |->
    wr_data_q == {16'(req_q.first_val[31:16] + req_q.second_val[15:0]),
                  16'(req_q.first_val[15:0] - req_q.second_val[31:16])})
    else $error("add-sub exchange wrong");
  AST_SUB_ADD_X: assert property (commit_q && req_q.op == phs_pkg::OP_SUB_ADD_X |->
    wr_data_q == {16'(req_q.first_val[31:16] - req_q.second_val[15:0]),
                  16'(req_q.first_val[15:0] + req_q.second_val[31:16])})
    else $error("sub-add exchange wrong");
  AST_BAD_REG_REFUSED: assert property (req_valid && bad_reg |=>
    reg_fault_q && !wr_en_q && $stable(flags_q))
    else $error("forbidden register was not refused");
  AST_TEST_NO_WRITE: assert property (req_valid && is_test |=> !wr_en_q)
    else $error("test operation wrote a register");
  AST_TEST_Z: assert property (commit && is_test |=>
    flags_q.z == (req_q.op == phs_pkg::OP_BIT_TEST ?
    ((req_q.first_val & req_q.second_val) == 32'h0)
    : ((req_q.first_val ^ req_q.second_val) == 32'h0)))
    else $error("test zero flag wrong");
  AST_TEST_V_C: assert property (commit && is_test |=> $stable(flags_q.v)
    && flags_q.c == (req_q.shift_carry_valid ? req_q.shift_carry : $past(flags_q.c)))
    else $error("test carry or overflow wrong");
  AST_EQUIV_N: assert property (commit && req.op == phs_pkg::OP_EQUIV_TEST |=>
    flags_q.n == (req_q.first_val[31] ^ req_q.second_val[31]))
    else $error("equivalence test negative flag wrong");
  AST_COND_FAIL: assert property (req_valid && !req.cond_pass |=>
    !wr_en_q && $stable(flags_q) && $stable(wr_data_q))
    else $error("failed condition committed state");
  AST_DEST_DEFAULT: assert property (commit_q && !req_q.dest_given && wr_en_q |->
    wr_idx_q == req_q.first_idx)
    else $error("omitted destination not first operand");
  AST_HALF_SIGN: assert property (commit_q && req_q.op == phs_pkg::OP_HALVE_ADD16 &&
    req_q.first_val[31] == req_q.second_val[31] |-> wr_data_q[31] == req_q.first_val[31])
    else $error("halved lane overflowed");
  AST_NO_LANE_CARRY: assert property (commit_q && req_q.op == phs_pkg::OP_LANE_SUB16 &&
    req_q.first_val[31:16] == req_q.second_val[31:16] |-> wr_data_q[31:16] == 16'h0)
    else $error("borrow crossed a lane");

  COV_HALVE_ASX: cover property (commit && req.op == phs_pkg::OP_HALVE_ADD_SUB_X);
  COV_EQUIV_NEG: cover property (commit && req.op == phs_pkg::OP_EQUIV_TEST ##1 flags_q.n);
  COV_COND_FAIL: cover property (req_valid && !req.cond_pass && !is_test);
  COV_BAD_REG:   cover property (req_valid && bad_reg);

endmodule : phs_alu
`default_nettype wire

// ==== rtl/phs_pkg.sv ====
// Shared types, constants and lane arithmetic for the packed halving lane datapath.
// Assumes the core pipeline supplies decoded operations and a resolved second operand.
package phs_pkg;

  localparam logic [3:0] STACK_PTR_IDX = 4'hd;
  localparam logic [3:0] PROG_CTR_IDX  = 4'hf;
  localparam logic [3:0] FLAGS_RST     = 4'h0;

  typedef enum logic [3:0] {
    OP_HALVE_ADD16     = 4'h0,
    OP_HALVE_ADD8      = 4'h1,
    OP_HALVE_ADD_SUB_X = 4'h2,
    OP_HALVE_SUB_ADD_X = 4'h3,
    OP_HALVE_SUB16     = 4'h4,
    OP_HALVE_SUB8      = 4'h5,
    OP_LANE_SUB16      = 4'h6,
    OP_LANE_SUB8       = 4'h7,
    OP_ADD_SUB_X       = 4'h8,
    OP_SUB_ADD_X       = 4'h9,
    OP_BIT_TEST        = 4'ha,
    OP_EQUIV_TEST      = 4'hb
  } phs_op_t;

  // The stack pointer and program counter may not be named by these operations.
  function automatic logic phs_resv_idx(input logic [3:0] idx);
    return (idx == STACK_PTR_IDX) || (idx == PROG_CTR_IDX);
  endfunction : phs_resv_idx

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } phs_flags_t;

  typedef struct packed {
    phs_op_t     op;
    logic        cond_pass;
    logic        dest_given;
    logic [3:0]  dest_idx;
    logic [3:0]  first_idx;
    logic [3:0]  second_idx;
    logic        second_is_reg;
    logic [31:0] first_val;
    logic [31:0] second_val;
    logic        shift_carry_valid;
    logic        shift_carry;
  } phs_req_t;

  // The sum or difference is kept one bit wider than the lane before halving.
  function automatic logic [15:0] phs_half16(input logic [15:0] a, input logic [15:0] b,
                                             input logic sub);
    logic [16:0] t;
    t = sub ? ({a[15], a} - {b[15], b}) : ({a[15], a} + {b[15], b});
    return t[16:1];
  endfunction : phs_half16

  function automatic logic [7:0] phs_half8(input logic [7:0] a, input logic [7:0] b,
                                           input logic sub);
    logic [8:0] t;
    t = sub ? ({a[7], a} - {b[7], b}) : ({a[7], a} + {b[7], b});
    return t[8:1];
  endfunction : phs_half8

endpackage : phs_pkg

// ==== rtl/phs_lane_unit.sv ====
// Combinational packed lane arithmetic: one 32-bit result for each lane operation.
// Assumes operands are stable within the cycle; test operations yield zero here.
`timescale 1ns/1ns
`default_nettype none
module phs_lane_unit (
  input  wire phs_pkg::phs_op_t op,
  input  wire logic [31:0]      a,
  input  wire logic [31:0]      b,
  output logic [31:0]           result
);

  always_comb
  begin
    result = 32'h0;
    unique case (op)
      phs_pkg::OP_HALVE_ADD16:
        result = {phs_pkg::phs_half16(a[31:16], b[31:16], 1'b0),
                  phs_pkg::phs_half16(a[15:0], b[15:0], 1'b0)};
      phs_pkg::OP_HALVE_ADD8:
      begin
        for (int i = 0; i < 4; i++)
          result[i*8 +: 8] = phs_pkg::phs_half8(a[i*8 +: 8], b[i*8 +: 8], 1'b0);
      end
      phs_pkg::OP_HALVE_ADD_SUB_X:
        result = {phs_pkg::phs_half16(a[31:16], b[15:0], 1'b0),
                  phs_pkg::phs_half16(a[15:0], b[31:16], 1'b1)};
      phs_pkg::OP_HALVE_SUB_ADD_X:
        result = {phs_pkg::phs_half16(a[31:16], b[15:0], 1'b1),
                  phs_pkg::phs_half16(a[15:0], b[31:16], 1'b0)};
      phs_pkg::OP_HALVE_SUB16:
        result = {phs_pkg::phs_half16(a[31:16], b[31:16], 1'b1),
                  phs_pkg::phs_half16(a[15:0], b[15:0], 1'b1)};
      phs_pkg::OP_HALVE_SUB8:
      begin
        for (int i = 0; i < 4; i++)
          result[i*8 +: 8] = phs_pkg::phs_half8(a[i*8 +: 8], b[i*8 +: 8], 1'b1);
      end
      // Lanes are computed separately so no borrow can cross a lane boundary.
      phs_pkg::OP_LANE_SUB16:
        result = {a[31:16] - b[31:16], a[15:0] - b[15:0]};
      phs_pkg::OP_LANE_SUB8:
      begin
        for (int i = 0; i < 4; i++)
          result[i*8 +: 8] = a[i*8 +: 8] - b[i*8 +: 8];
      end
      phs_pkg::OP_ADD_SUB_X:
        result = {a[31:16] + b[15:0], a[15:0] - b[31:16]};
      phs_pkg::OP_SUB_ADD_X:
        result = {a[31:16] - b[15:0], a[15:0] + b[31:16]};
      default:
        result = 32'h0;
    endcase
  end

endmodule : phs_lane_unit
`default_nettype wire

// ==== bench/phs_alu_bench.sv ====
// Self-checking bench for the packed halving lane datapath with flag tests.
// Assumes phs_pkg and phs_alu are compiled first; requests are driven on falling edges.
`timescale 1ns/1ns
`default_nettype none
module phs_alu_bench;
  logic                clk;
  logic                rst;
  logic                req_valid;
  phs_pkg::phs_req_t   req;
  logic                done_q;
  logic                wr_en_q;
  logic [3:0]          wr_idx_q;
  logic [31:0]         wr_data_q;
  logic                reg_fault_q;
  phs_pkg::phs_flags_t flags_q;
  int                  errors;
  int                  comparisons;
  int                  cycles;
  phs_pkg::phs_flags_t mflags;
  logic [31:0]         mdata;
  logic [3:0]          midx;
  logic [31:0]         pa [3];
  logic [31:0]         pb [3];

  phs_alu uut (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req), .done_q(done_q),
               .wr_en_q(wr_en_q), .wr_idx_q(wr_idx_q), .wr_data_q(wr_data_q),
               .reg_fault_q(reg_fault_q), .flags_q(flags_q));

  ////////////////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // The ceiling leaves ample margin over the roughly fifty cycles of traffic.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      errors = errors + 1;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task automatic chk_w(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_w

  task automatic chk_f(input phs_pkg::phs_flags_t exp, input phs_pkg::phs_flags_t got);
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("BAD flags_q expected %b seen %b", exp, got);
    end
  endtask : chk_f

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Reference halving keeps a seventeenth bit so extreme operands never wrap.
  function automatic logic [15:0] hf(input logic [15:0] x, input logic [15:0] y, input logic s);
    logic [16:0] t;
    t = s ? ({x[15], x} - {y[15], y}) : ({x[15], x} + {y[15], y});
    return t[16:1];
  endfunction : hf

  function automatic logic [31:0] lane(input logic [3:0] op, input logic [31:0] a,
                                       input logic [31:0] b);
    logic [31:0] r;
    logic [8:0]  t;
    r = 32'h0;
    case (op)
      4'h0: r = {hf(a[31:16], b[31:16], 1'b0), hf(a[15:0], b[15:0], 1'b0)};
      4'h2: r = {hf(a[31:16], b[15:0], 1'b0), hf(a[15:0], b[31:16], 1'b1)};
      4'h3: r = {hf(a[31:16], b[15:0], 1'b1), hf(a[15:0], b[31:16], 1'b0)};
      4'h4: r = {hf(a[31:16], b[31:16], 1'b1), hf(a[15:0], b[15:0], 1'b1)};
      4'h6: r = {a[31:16] - b[31:16], a[15:0] - b[15:0]};
      4'h8: r = {a[31:16] + b[15:0], a[15:0] - b[31:16]};
      4'h9: r = {a[31:16] - b[15:0], a[15:0] + b[31:16]};
      4'h1, 4'h5, 4'h7:
        for (int i = 0; i < 4; i++)
        begin
          t = (op == 4'h1) ? ({a[8*i+7], a[8*i+:8]} + {b[8*i+7], b[8*i+:8]})
                           : ({a[8*i+7], a[8*i+:8]} - {b[8*i+7], b[8*i+:8]});
          r[8*i+:8] = (op == 4'h7) ? t[7:0] : t[8:1];
        end
      default: r = 32'h0;
    endcase
    return r;
  endfunction : lane

  // Drives one request at a falling edge and checks its answer one falling edge later,
  // so consecutive calls are issued back to back with req_valid held high.
  task automatic go(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b,
                    input logic cp, input logic dg, input logic [3:0] dst, input logic [3:0] fi,
                    input logic [3:0] si, input logic sir, input logic scv, input logic sc);
    logic tst;
    logic flt;
    logic com;
    logic [31:0] r;
    tst = (op >= 4'ha);
    flt = (fi == 4'hd || fi == 4'hf) || (sir && (si == 4'hd || si == 4'hf))
          || (dg && !tst && (dst == 4'hd || dst == 4'hf));
    com = cp && !flt;
    req = '{op: phs_pkg::phs_op_t'(op), cond_pass: cp, dest_given: dg, dest_idx: dst,
            first_idx: fi, second_idx: si, second_is_reg: sir, first_val: a, second_val: b,
            shift_carry_valid: scv, shift_carry: sc};
    req_valid = 1'b1;
    if (com && !tst)
    begin
      mdata = lane(op, a, b);
      midx  = dg ? dst : fi;
    end
    if (com && tst)
    begin
      r = (op == 4'ha) ? (a & b) : (a ^ b);
      mflags.n = r[31];
      mflags.z = (r == 32'h0);
      mflags.c = scv ? sc : mflags.c;
    end
    @(negedge clk);
    chk_w("done_q", 32'h1, {31'h0, done_q});
    chk_w("wr_en_q", {31'h0, com && !tst}, {31'h0, wr_en_q});
    chk_w("reg_fault_q", {31'h0, flt}, {31'h0, reg_fault_q});
    chk_w("wr_idx_q", {28'h0, midx}, {28'h0, wr_idx_q});
    chk_w("wr_data_q", mdata, wr_data_q);
    chk_f(mflags, flags_q);
  endtask : go

  task automatic run_set(input int lo, input int hi);
    for (int k = lo; k <= hi; k++)
      for (int j = 0; j < 3; j++)
        go(k[3:0], pa[j], pb[j], 1, j != 1, 4'(j + 5), 4'h4, 4'h6, 1, 0, 0);
  endtask : run_set

  ////////////////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    errors = 0;
    comparisons = 0;
    cycles = 0;
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    mflags = '0;
    mdata = 32'h0;
    midx = 4'h0;
    pa = '{32'h80007fff, 32'h7f80017f, 32'h12345678};
    pb = '{32'h7fff8000, 32'h80ff7f81, 32'hfedcba98};
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk_w("out", 32'h0, {done_q, wr_en_q, reg_fault_q, wr_data_q[28:0]});
    chk_f('0, flags_q);
    go(4'hb, 32'h80000000, 32'h00000001, 1, 1, 4'hf, 4'h1, 4'h0, 0, 1, 1);
    go(4'ha, 32'h0f0f0000, 32'hf0f0ffff, 1, 0, 4'h0, 4'h2, 4'h3, 1, 0, 0);
    go(4'hb, 32'h00000001, 32'h00000001, 0, 0, 4'h0, 4'h2, 4'h3, 1, 1, 0);
    go(4'h6, 32'h00050005, 32'h00010001, 0, 1, 4'h3, 4'h1, 4'h2, 1, 0, 0);
    go(4'h2, 32'h11112222, 32'h33334444, 1, 1, 4'h3, 4'hd, 4'h2, 1, 0, 0);
    go(4'h2, 32'h11112222, 32'h33334444, 1, 1, 4'hf, 4'h1, 4'h2, 1, 0, 0);
    go(4'h9, 32'h11112222, 32'h33334444, 1, 1, 4'h3, 4'h1, 4'hf, 1, 0, 0);
    run_set(0, 4);
    run_set(5, 9);
    req_valid = 1'b0;
    @(negedge clk);
    chk_w("done_q", 32'h0, {31'h0, done_q});
    close_out();
  end
endmodule : phs_alu_bench
`default_nettype wire
